// File: usbec_top.sv
// The implementer's own choices: the strobed register port and the address map.
`timescale 1ns/1ps
module usbec_top
  import usbec_pkg::*;
#(
  parameter int NEP = USBEC_NEP
)(
  input  wire logic                    clk_sys,
  input  wire logic                    nrst,
  input  wire logic [USBEC_ADDR_W-1:0] reg_addr,
  input  wire logic [31:0]             reg_wdata,
  input  wire logic                    reg_wr,
  input  wire logic                    reg_rd,
  output logic [31:0]                  reg_rdata,
  input  wire logic                    frame_start_seen,
  input  wire logic                    bus_reset_end_seen,
  input  wire logic                    wakeup_seen,
  input  wire usbec_ev_t [NEP-1:0]     ep_ev,
  output usbec_rsp_t [NEP-1:0]         ep_rsp,
  output logic [NEP-1:0]               ep_int_status
);

  // ---------------------------------------------------------------
  // Elaboration check
  // ---------------------------------------------------------------
  if (NEP < 1 || NEP > 8) begin : g_nep_check
    $error("usbec_top: NEP must be 1 to 8");
  end

  // ---------------------------------------------------------------
  // Address decode
  // ---------------------------------------------------------------
  // Endpoint control/status word address match
  function automatic logic csr_hit(input logic [USBEC_ADDR_W-1:0] a, input int ep);
    logic [USBEC_ADDR_W-1:0] base;
    base = USBEC_OFS_CSR + USBEC_CSR_STEP * ep[USBEC_ADDR_W-1:0];
    return a == base;
  endfunction

  logic                   icr_wr;
  logic                   rst_wr;
  logic [NEP-1:0]         csr_wr;

  // Write strobes per register
  always_comb begin
    icr_wr = reg_wr && (reg_addr == USBEC_OFS_ICR);
    rst_wr = reg_wr && (reg_addr == USBEC_OFS_RST);
    for (int i = 0; i < NEP; i++) begin
      csr_wr[i] = reg_wr && csr_hit(reg_addr, i);
    end
  end

  // ---------------------------------------------------------------
  // Global event flags and endpoint reset register
  // ---------------------------------------------------------------
  logic           frame_start_irq;
  logic           bus_reset_done_irq;
  logic           wakeup_irq;
  logic [NEP-1:0] fifo_reset;
  logic           next_frame_start_irq;
  logic           next_bus_reset_done_irq;
  logic           next_wakeup_irq;
  logic [NEP-1:0] next_fifo_reset;

  // Sticky events, set wins over a write-one clear
  always_comb begin
    next_frame_start_irq = frame_start_seen |
      (frame_start_irq & ~(icr_wr & reg_wdata[USBEC_B_SOF]));
    next_bus_reset_done_irq = bus_reset_end_seen |
      (bus_reset_done_irq & ~(icr_wr & reg_wdata[USBEC_B_BUSRES]));
    next_wakeup_irq = wakeup_seen |
      (wakeup_irq & ~(icr_wr & reg_wdata[USBEC_B_WAKE]));
    next_fifo_reset = rst_wr ? reg_wdata[NEP-1:0] : fifo_reset;
  end

  // Event and reset registers
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      frame_start_irq    <= 1'b0;
      bus_reset_done_irq <= 1'b0;
      wakeup_irq         <= 1'b0;
      fifo_reset         <= '0;
    end else begin
      frame_start_irq    <= next_frame_start_irq;
      bus_reset_done_irq <= next_bus_reset_done_irq;
      wakeup_irq         <= next_wakeup_irq;
      fifo_reset         <= next_fifo_reset;
    end
  end

  // ---------------------------------------------------------------
  // Endpoints
  // ---------------------------------------------------------------
  usbec_flags_t [NEP-1:0]  flags;
  logic [NEP-1:0]          active;
  logic [USBEC_CNT_W-1:0]  count [NEP];
  logic [NEP-1:0]          toggle;
  logic [NEP-1:0]          next_ep_int;

  for (genvar i = 0; i < NEP; i++) begin : g_ep
    usbec_ep_flags u_flags (
      .clk_sys (clk_sys),
      .nrst    (nrst),
      .ev      (ep_ev[i]),
      .csr_wr  (csr_wr[i]),
      .wdata   (reg_wdata),
      .flags   (flags[i]),
      .active  (active[i])
    );

    usbec_ep_fifo u_fifo (
      .clk_sys             (clk_sys),
      .nrst                (nrst),
      .ev                  (ep_ev[i]),
      .fifo_reset          (fifo_reset[i]),
      .received_byte_count (count[i]),
      .data_toggle_state   (toggle[i])
    );

    // Replies to the serial engine, all from flops
    assign ep_rsp[i].halt_reply        = flags[i].force_halt_reply;
    assign ep_rsp[i].refuse_out        = flags[i].setup_received;
    assign ep_rsp[i].payload_ready     = flags[i].transmit_ready;
    assign ep_rsp[i].active            = active[i];
    assign ep_rsp[i].data_toggle_state = toggle[i];
    assign ep_rsp[i].dir_in            = flags[i].dir_in;
  end

  // Endpoint interrupt status from the set flags
  always_comb begin
    for (int i = 0; i < NEP; i++) begin
      next_ep_int[i] = flags[i].setup_received |
                       flags[i].receive_bank_zero_full |
                       flags[i].receive_bank_one_full |
                       flags[i].transmit_complete |
                       flags[i].halt_acknowledged;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      ep_int_status <= '0;
    end else begin
      ep_int_status <= next_ep_int;
    end
  end

  // ---------------------------------------------------------------
  // Read data
  // ---------------------------------------------------------------
  logic [31:0] next_rdata;

  // Read mux; unmapped and write-only offsets read zero
  always_comb begin
    next_rdata = '0;
    if (reg_rd) begin
      if (reg_addr == USBEC_OFS_STAT) begin
        next_rdata[NEP-1:0]      = ep_int_status;
        next_rdata[USBEC_B_SOF]    = frame_start_irq;
        next_rdata[USBEC_B_BUSRES] = bus_reset_done_irq;
        next_rdata[USBEC_B_WAKE]   = wakeup_irq;
      end else if (reg_addr == USBEC_OFS_RST) begin
        next_rdata[NEP-1:0] = fifo_reset;
      end
      for (int i = 0; i < NEP; i++) begin
        if (csr_hit(reg_addr, i)) begin
          next_rdata[USBEC_B_TXDONE]         = flags[i].transmit_complete;
          next_rdata[USBEC_B_BANK0]          = flags[i].receive_bank_zero_full;
          next_rdata[USBEC_B_SETUP]          = flags[i].setup_received;
          next_rdata[USBEC_B_HALTAK]         = flags[i].halt_acknowledged;
          next_rdata[USBEC_B_TXRDY]          = flags[i].transmit_ready;
          next_rdata[USBEC_B_FHALT]          = flags[i].force_halt_reply;
          next_rdata[USBEC_B_BANK1]          = flags[i].receive_bank_one_full;
          next_rdata[USBEC_B_DIR]            = flags[i].dir_in;
          next_rdata[USBEC_B_KIND +: 3]      = flags[i].endpoint_kind;
          next_rdata[USBEC_B_TOGGLE]         = toggle[i];
          next_rdata[USBEC_B_ENABLE]         = active[i];
          next_rdata[USBEC_B_COUNT +: USBEC_CNT_W] = count[i];
        end
      end
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      reg_rdata <= '0;
    end else begin
      reg_rdata <= next_rdata;
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!nrst);

  property p_sof_clear;
    icr_wr && reg_wdata[USBEC_B_SOF] && !frame_start_seen |=> !frame_start_irq;
  endproperty
  a_sof_clear: assert property (p_sof_clear)
    else $error("frame start flag not cleared by write one");

  property p_busres_keep;
    bus_reset_done_irq && icr_wr && !reg_wdata[USBEC_B_BUSRES] |=> bus_reset_done_irq;
  endproperty
  a_busres_keep: assert property (p_busres_keep)
    else $error("bus reset flag lost on write zero");

  for (genvar i = 0; i < NEP; i++) begin : g_chk
    sequence s_arm;
      ep_rsp[i].payload_ready && !(csr_wr[i] && reg_wdata[USBEC_B_TXRDY]);
    endsequence
    sequence s_acked;
      ep_ev[i].in_acked;
    endsequence

    property p_fifo_reset;
      fifo_reset[i] [*2] |-> count[i] == '0 && !toggle[i];
    endproperty
    a_fifo_reset: assert property (p_fifo_reset)
      else $error("endpoint reset did not zero count and toggle");

    property p_txdone_clear;
      csr_wr[i] && !reg_wdata[USBEC_B_TXDONE] && !ep_ev[i].in_acked
        |=> !flags[i].transmit_complete;
    endproperty
    a_txdone_clear: assert property (p_txdone_clear)
      else $error("transmit complete not cleared by write zero");

    property p_bank0_set;
      ep_ev[i].bank0_stored |=> flags[i].receive_bank_zero_full ##1 ep_int_status[i];
    endproperty
    a_bank0_set: assert property (p_bank0_set)
      else $error("bank zero flag or interrupt missing");

    property p_bank1_keep;
      flags[i].receive_bank_one_full && csr_wr[i] && reg_wdata[USBEC_B_BANK1]
        |=> flags[i].receive_bank_one_full;
    endproperty
    a_bank1_keep: assert property (p_bank1_keep)
      else $error("bank one flag changed by write one");

    property p_setup_refuse;
      ep_ev[i].setup_stored |=> ep_rsp[i].refuse_out;
    endproperty
    a_setup_refuse: assert property (p_setup_refuse)
      else $error("OUT not refused after setup");

    property p_halt_kind;
      ep_ev[i].crc_fault && !ep_ev[i].halt_acked && !flags[i].halt_acknowledged
        && flags[i].endpoint_kind[1:0] != USBEC_KIND_ISO |=> !flags[i].halt_acknowledged;
    endproperty
    a_halt_kind: assert property (p_halt_kind)
      else $error("crc fault flagged on non-isochronous endpoint");

    property p_transmit;
      s_arm ##0 s_acked |=> flags[i].transmit_complete && !ep_rsp[i].payload_ready;
    endproperty
    a_transmit: assert property (p_transmit)
      else $error("transmit ready not retired on host ack");

    property p_force_halt;
      csr_wr[i] |=> ep_rsp[i].halt_reply == $past(reg_wdata[USBEC_B_FHALT]);
    endproperty
    a_force_halt: assert property (p_force_halt)
      else $error("halt reply does not follow force bit");

    property p_control_active;
      flags[i].endpoint_kind == USBEC_KIND_CTL |-> active[i];
    endproperty
    a_control_active: assert property (p_control_active)
      else $error("control endpoint not active");
  end

endmodule

// File: usbec_pkg.sv
package usbec_pkg;

  // ---------------------------------------------------------------
  // Sizes
  // ---------------------------------------------------------------
  localparam int          USBEC_NEP      = 4;
  localparam int          USBEC_CNT_W    = 11;
  localparam int          USBEC_ADDR_W   = 8;

  // ---------------------------------------------------------------
  // Register byte offsets
  // ---------------------------------------------------------------
  localparam logic [7:0]  USBEC_OFS_STAT = 8'h1c;
  localparam logic [7:0]  USBEC_OFS_ICR  = 8'h20;
  localparam logic [7:0]  USBEC_OFS_RST  = 8'h28;
  localparam logic [7:0]  USBEC_OFS_CSR  = 8'h30;
  localparam logic [7:0]  USBEC_CSR_STEP = 8'h04;

  // ---------------------------------------------------------------
  // Interrupt status and clear bit positions
  // ---------------------------------------------------------------
  localparam int          USBEC_B_SOF    = 11;
  localparam int          USBEC_B_BUSRES = 12;
  localparam int          USBEC_B_WAKE   = 13;

  // ---------------------------------------------------------------
  // Endpoint control/status field positions
  // ---------------------------------------------------------------
  localparam int          USBEC_B_TXDONE = 0;
  localparam int          USBEC_B_BANK0  = 1;
  localparam int          USBEC_B_SETUP  = 2;
  localparam int          USBEC_B_HALTAK = 3;
  localparam int          USBEC_B_TXRDY  = 4;
  localparam int          USBEC_B_FHALT  = 5;
  localparam int          USBEC_B_BANK1  = 6;
  localparam int          USBEC_B_DIR    = 7;
  localparam int          USBEC_B_KIND   = 8;
  localparam int          USBEC_B_TOGGLE = 11;
  localparam int          USBEC_B_ENABLE = 15;
  localparam int          USBEC_B_COUNT  = 16;

  // Endpoint kind codes
  localparam logic [2:0]  USBEC_KIND_CTL = 3'h0;
  localparam logic [1:0]  USBEC_KIND_ISO = 2'h1;

  // Events from the serial engine, one set per endpoint
  typedef struct packed {
    logic                   in_acked;
    logic                   bank0_stored;
    logic                   bank1_stored;
    logic                   setup_stored;
    logic                   halt_acked;
    logic                   crc_fault;
    logic                   toggle_flip;
    logic [USBEC_CNT_W-1:0] byte_count;
  } usbec_ev_t;

  // Firmware-visible endpoint flags
  typedef struct packed {
    logic       endpoint_enable;
    logic [2:0] endpoint_kind;
    logic       dir_in;
    logic       receive_bank_one_full;
    logic       force_halt_reply;
    logic       transmit_ready;
    logic       halt_acknowledged;
    logic       setup_received;
    logic       receive_bank_zero_full;
    logic       transmit_complete;
  } usbec_flags_t;

  // Replies to the serial engine, one set per endpoint
  typedef struct packed {
    logic halt_reply;
    logic refuse_out;
    logic payload_ready;
    logic active;
    logic data_toggle_state;
    logic dir_in;
  } usbec_rsp_t;

endpackage

// File: usbec_ep_flags.sv
`timescale 1ns/1ps
module usbec_ep_flags
  import usbec_pkg::*;
(
  input  wire logic         clk_sys,
  input  wire logic         nrst,
  input  wire usbec_ev_t    ev,
  input  wire logic         csr_wr,
  input  wire logic [31:0]  wdata,
  output usbec_flags_t      flags,
  output logic              active
);

  usbec_flags_t next_flags;
  logic         next_active;
  logic         iso;

  // ---------------------------------------------------------------
  // Flag updates: hardware set wins over firmware clear
  // ---------------------------------------------------------------
  always_comb begin
    iso        = (flags.endpoint_kind[1:0] == USBEC_KIND_ISO);
    next_flags = flags;
    next_flags.transmit_complete = ev.in_acked |
      (flags.transmit_complete & ~(csr_wr & ~wdata[USBEC_B_TXDONE]));
    next_flags.receive_bank_zero_full = ev.bank0_stored |
      (flags.receive_bank_zero_full & ~(csr_wr & ~wdata[USBEC_B_BANK0]));
    next_flags.receive_bank_one_full = ev.bank1_stored |
      (flags.receive_bank_one_full & ~(csr_wr & ~wdata[USBEC_B_BANK1]));
    next_flags.setup_received = ev.setup_stored |
      (flags.setup_received & ~(csr_wr & ~wdata[USBEC_B_SETUP]));
    next_flags.halt_acknowledged = (iso ? ev.crc_fault : ev.halt_acked) |
      (flags.halt_acknowledged & ~(csr_wr & ~wdata[USBEC_B_HALTAK]));
    // Firmware arms, device disarms once the host took the data
    next_flags.transmit_ready = (csr_wr & wdata[USBEC_B_TXRDY]) |
      (flags.transmit_ready & ~ev.in_acked);
    if (csr_wr) begin
      next_flags.force_halt_reply = wdata[USBEC_B_FHALT];
      next_flags.dir_in           = wdata[USBEC_B_DIR];
      next_flags.endpoint_kind    = wdata[USBEC_B_KIND +: 3];
      next_flags.endpoint_enable  = wdata[USBEC_B_ENABLE];
    end
    // Control endpoints are always enabled
    next_active = next_flags.endpoint_enable |
                  (next_flags.endpoint_kind == USBEC_KIND_CTL);
  end

  // Flag registers, control kind after reset
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      flags  <= '0;
      active <= 1'b1;
    end else begin
      flags  <= next_flags;
      active <= next_active;
    end
  end

endmodule

// File: usbec_ep_fifo.sv
`timescale 1ns/1ps
module usbec_ep_fifo
  import usbec_pkg::*;
(
  input  wire logic                   clk_sys,
  input  wire logic                   nrst,
  input  wire usbec_ev_t              ev,
  input  wire logic                   fifo_reset,
  output logic [USBEC_CNT_W-1:0]      received_byte_count,
  output logic                        data_toggle_state
);

  logic [USBEC_CNT_W-1:0] next_count;
  logic                   next_toggle;

  // ---------------------------------------------------------------
  // Byte count and toggle, both held at zero during a reset
  // ---------------------------------------------------------------
  always_comb begin
    next_count  = received_byte_count;
    next_toggle = data_toggle_state ^ ev.toggle_flip;
    if (ev.bank0_stored | ev.bank1_stored | ev.setup_stored) begin
      next_count = ev.byte_count;
    end
    if (fifo_reset) begin
      next_count  = '0;
      next_toggle = 1'b0;
    end
  end

  // Count and toggle registers
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      received_byte_count <= '0;
      data_toggle_state   <= 1'b0;
    end else begin
      received_byte_count <= next_count;
      data_toggle_state   <= next_toggle;
    end
  end

endmodule

// File: usbec_host_model.sv
`timescale 1ns/1ps
module usbec_host_model
  import usbec_pkg::*;
#(
  parameter int NEP = USBEC_NEP
)(
  input  wire logic                   clk_sys,
  input  wire logic                   nrst,
  input  wire usbec_rsp_t [NEP-1:0]   ep_rsp,
  input  wire logic                   cmd_valid,
  input  wire logic [1:0]             cmd_ep,
  input  wire logic [3:0]             cmd_kind,
  input  wire logic [USBEC_CNT_W-1:0] cmd_count,
  output usbec_ev_t [NEP-1:0]         ep_ev,
  output logic                        frame_start_seen,
  output logic                        bus_reset_end_seen,
  output logic                        wakeup_seen
);
  usbec_ev_t [NEP-1:0] next_ep_ev;
  logic [2:0]          next_bus;

  // Host side of one bus transaction, decided from the endpoint replies
  always_comb begin
    next_ep_ev = '0;
    next_bus   = 3'h0;
    for (int i = 0; i < NEP; i++) begin
      next_ep_ev[i].byte_count = ~ep_ev[i].byte_count;  // Count not held between packets
    end
    if (cmd_valid) begin
      case (cmd_kind)
        4'h0: begin
          if (ep_rsp[cmd_ep].halt_reply) begin
            next_ep_ev[cmd_ep].halt_acked = 1'b1;
          end else if (ep_rsp[cmd_ep].payload_ready) begin
            next_ep_ev[cmd_ep].in_acked = 1'b1;
          end
        end
        4'h1: begin
          if (ep_rsp[cmd_ep].halt_reply) begin
            next_ep_ev[cmd_ep].halt_acked = 1'b1;
          end else if (!ep_rsp[cmd_ep].refuse_out) begin
            next_ep_ev[cmd_ep].bank0_stored = 1'b1;
            next_ep_ev[cmd_ep].toggle_flip  = 1'b1;
            next_ep_ev[cmd_ep].byte_count   = cmd_count;
          end
        end
        4'h2: begin
          next_ep_ev[cmd_ep].bank1_stored = 1'b1;
          next_ep_ev[cmd_ep].byte_count   = cmd_count;
        end
        4'h3: begin
          next_ep_ev[cmd_ep].setup_stored = 1'b1;
          next_ep_ev[cmd_ep].byte_count   = cmd_count;
        end
        4'h4: next_ep_ev[cmd_ep].crc_fault = 1'b1;
        4'h5: next_bus = 3'h1;
        4'h6: next_bus = 3'h2;
        4'h7: next_bus = 3'h4;
        default: next_bus = 3'h0;
      endcase
    end
  end

  // Events are one-cycle pulses
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      ep_ev              <= '0;
      frame_start_seen   <= 1'b0;
      bus_reset_end_seen <= 1'b0;
      wakeup_seen        <= 1'b0;
    end else begin
      ep_ev              <= next_ep_ev;
      frame_start_seen   <= next_bus[0];
      bus_reset_end_seen <= next_bus[1];
      wakeup_seen        <= next_bus[2];
    end
  end
endmodule

// File: usbec_top_tb_top.sv
`timescale 1ns/1ps
module usbec_top_tb_top
  import usbec_pkg::*;
;
  logic                    clk_sys;
  logic                    nrst;
  logic [USBEC_ADDR_W-1:0] reg_addr;
  logic [31:0]             reg_wdata;
  logic                    reg_wr;
  logic                    reg_rd;
  logic [31:0]             reg_rdata;
  logic                    fs_seen;
  logic                    br_seen;
  logic                    wk_seen;
  usbec_ev_t [3:0]         ep_ev;
  usbec_rsp_t [3:0]        ep_rsp;
  logic [3:0]              ep_int_status;
  logic                    cmd_valid;
  logic [1:0]              cmd_ep;
  logic [3:0]              cmd_kind;
  logic [10:0]             cmd_count;
  int                      miscompares;
  int                      comparisons;

  usbec_top #(.NEP(4)) dut_u (.clk_sys(clk_sys), .nrst(nrst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .frame_start_seen(fs_seen), .bus_reset_end_seen(br_seen), .wakeup_seen(wk_seen),
    .ep_ev(ep_ev), .ep_rsp(ep_rsp), .ep_int_status(ep_int_status));

  usbec_host_model #(.NEP(4)) host_u (.clk_sys(clk_sys), .nrst(nrst), .ep_rsp(ep_rsp),
    .cmd_valid(cmd_valid), .cmd_ep(cmd_ep), .cmd_kind(cmd_kind), .cmd_count(cmd_count),
    .ep_ev(ep_ev), .frame_start_seen(fs_seen), .bus_reset_end_seen(br_seen),
    .wakeup_seen(wk_seen));

  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  task automatic finish_test();
    if (miscompares == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: %s got %h want %h", $time, what, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr    <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    @(posedge clk_sys);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd   <= 1'b0;
    #1;
    check(reg_rdata & m, e, "register read");
  endtask

  // Host transaction, then settle flags and interrupt status
  task automatic host(input logic [3:0] k, input logic [1:0] ep, input logic [10:0] n);
    @(posedge clk_sys);
    cmd_valid <= 1'b1;
    cmd_kind  <= k;
    cmd_ep    <= ep;
    cmd_count <= n;
    @(posedge clk_sys);
    cmd_valid <= 1'b0;
    repeat (3) @(posedge clk_sys);
    #1;
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic test_reset();
    rd(USBEC_OFS_CSR, 32'hffffffff, 32'h00008000);
    wr(8'h38, 32'h00000000);
    rd(8'h38, 32'h00008700, 32'h00008000);
    check({31'h0, ep_rsp[3].active}, 32'h1, "control active");
    rd(USBEC_OFS_ICR, 32'hffffffff, 32'h0);
    rd(8'h04, 32'hffffffff, 32'h0);
  endtask

  task automatic test_irq_clear();
    host(4'h5, 2'h0, 11'h0);
    host(4'h6, 2'h0, 11'h0);
    host(4'h7, 2'h0, 11'h0);
    rd(USBEC_OFS_STAT, 32'h3800, 32'h3800);
    wr(USBEC_OFS_ICR, 32'h0);
    rd(USBEC_OFS_STAT, 32'h3800, 32'h3800);
    wr(USBEC_OFS_ICR, 32'h800);
    rd(USBEC_OFS_STAT, 32'h3800, 32'h3000);
    wr(USBEC_OFS_ICR, 32'h3000);
    rd(USBEC_OFS_STAT, 32'h3800, 32'h0);
  endtask

  task automatic test_bank();
    host(4'h1, 2'h1, 11'h040);
    rd(8'h34, 32'h07ff087f, 32'h00400802);
    check({28'h0, ep_int_status}, 32'h2, "ep int");
    wr(8'h34, 32'h4f);
    rd(8'h34, 32'h07ff087f, 32'h00400802);
    host(4'h2, 2'h1, 11'h013);
    rd(8'h34, 32'h07ff087f, 32'h00130842);
    wr(8'h34, 32'h4d);
    rd(8'h34, 32'h07ff087f, 32'h00130840);
    wr(8'h34, 32'h0f);
    rd(8'h34, 32'h07ff087f, 32'h00130800);
    check({28'h0, ep_int_status}, 32'h0, "ep int idle");
    wr(USBEC_OFS_RST, 32'h2);
    host(4'h1, 2'h1, 11'h055);
    rd(8'h34, 32'h07ff087f, 32'h00000002);
    check({31'h0, ep_rsp[1].data_toggle_state}, 32'h0, "toggle held");
    rd(USBEC_OFS_RST, 32'hf, 32'h2);
    wr(USBEC_OFS_RST, 32'h0);
    wr(8'h34, 32'h4d);
    rd(8'h34, 32'h7f, 32'h0);
  endtask

  task automatic test_setup();
    host(4'h3, 2'h0, 11'h008);
    rd(USBEC_OFS_CSR, 32'h07ff007f, 32'h00080004);
    check({31'h0, ep_rsp[0].refuse_out}, 32'h1, "out refused");
    host(4'h1, 2'h0, 11'h020);
    rd(USBEC_OFS_CSR, 32'h07ff007f, 32'h00080004);
    wr(USBEC_OFS_CSR, 32'hcb);
    rd(USBEC_OFS_CSR, 32'h07ff00ff, 32'h00080080);
    check({31'h0, ep_rsp[0].refuse_out}, 32'h0, "out accepted");
    check({31'h0, ep_rsp[0].dir_in}, 32'h1, "direction in");
  endtask

  task automatic test_transmit();
    host(4'h0, 2'h2, 11'h0);
    rd(8'h38, 32'h7f, 32'h0);
    wr(8'h38, 32'h5f);
    rd(8'h38, 32'h7f, 32'h10);
    check({31'h0, ep_rsp[2].payload_ready}, 32'h1, "payload armed");
    host(4'h0, 2'h2, 11'h0);
    rd(8'h38, 32'h7f, 32'h01);
    check({28'h0, ep_int_status}, 32'h4, "tx int");
    wr(8'h38, 32'h4e);
    rd(8'h38, 32'h7f, 32'h0);
    host(4'h4, 2'h2, 11'h0);
    rd(8'h38, 32'h7f, 32'h0);
  endtask

  task automatic test_halt();
    wr(8'h3c, 32'h6f);
    rd(8'h3c, 32'h7f, 32'h20);
    check({31'h0, ep_rsp[3].halt_reply}, 32'h1, "halt reply");
    host(4'h0, 2'h3, 11'h0);
    rd(8'h3c, 32'h7f, 32'h28);
    wr(8'h3c, 32'h67);
    rd(8'h3c, 32'h7f, 32'h20);
    wr(8'h3c, 32'h4f);
    rd(8'h3c, 32'h7f, 32'h0);
    wr(8'h3c, 32'h14f);
    host(4'h4, 2'h3, 11'h007);
    rd(8'h3c, 32'h77f, 32'h108);
    wr(8'h3c, 32'h147);
    rd(8'h3c, 32'h77f, 32'h100);
  endtask

  // ---------------------------------------------------------------
  // Clock, reset, sequence and watchdog
  // ---------------------------------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  initial begin
    nrst        = 1'b0;
    reg_addr    = 8'h00;
    reg_wdata   = 32'h0;
    reg_wr      = 1'b0;
    reg_rd      = 1'b0;
    cmd_valid   = 1'b0;
    cmd_ep      = 2'h0;
    cmd_kind    = 4'h0;
    cmd_count   = 11'h000;
    miscompares = 0;
    comparisons = 0;
    repeat (10) @(posedge clk_sys);
    nrst <= 1'b1;
    test_reset();
    test_irq_clear();
    test_bank();
    test_setup();
    test_transmit();
    test_halt();
    finish_test();
  end

  initial begin
    repeat (20000) @(posedge clk_sys);
    miscompares++;
    finish_test();
  end
endmodule
